//--- bench/mpss_chk.sv
// port assertions for the power and sleep sequencer
`timescale 1ns/1ps
`default_nettype none
module mpss_chk #(
   parameter int unsigned PWRON_CYCLES  = 20,
   parameter int unsigned RSTMAX_CYCLES = 2000
) (
   // clock, reset, pins
   input wire logic CORE_CLK_I,
   input wire logic SYS_RST_I,
   input wire logic POWER_KEY_N_I,
   input wire logic RESET_N_I,
   input wire logic DTR_I,
   // watched outputs
   input wire logic STATUS_O,
   input wire logic RI_O,
   input wire logic USB_REMOTE_WAKE_O,
   input wire logic SLEEP_O,
   input wire logic CORE_RESET_O
);
   // raw low runs; synchroniser delay only lengthens them
   logic [23:0] key_lo_q;
   logic [23:0] rst_lo_q;
   logic [23:0] rst_len_q;
   always_ff @(posedge CORE_CLK_I) begin
      key_lo_q <= POWER_KEY_N_I ? 24'h00_0000 : key_lo_q + 24'h00_0001;
      rst_lo_q <= RESET_N_I ? 24'h00_0000 : rst_lo_q + 24'h00_0001;
      if (RESET_N_I && (rst_lo_q != 24'h00_0000))
         rst_len_q <= rst_lo_q;
   end
   default clocking cb @(posedge CORE_CLK_I); endclocking
   default disable iff (SYS_RST_I);
   a_on_key_len:
      assert property ($rose(STATUS_O) && !CORE_RESET_O && !$past(CORE_RESET_O)
         && !$past(CORE_RESET_O, 2) |-> key_lo_q >= PWRON_CYCLES) else $error("short key on");
   a_ri_pulse:
      assert property (RI_O |=> !RI_O) else $error("ri too long");
   a_rwake_pulse:
      assert property (USB_REMOTE_WAKE_O |=> !USB_REMOTE_WAKE_O) else $error("wake too long");
   a_rwake_sleep:
      assert property (USB_REMOTE_WAKE_O |-> SLEEP_O || $past(SLEEP_O))
         else $error("wake while awake");
   a_sleep_dtr:
      assert property ($rose(SLEEP_O) |-> $past(DTR_I, 3) && $past(DTR_I, 4))
         else $error("sleep with dtr low");
   a_rst_width:
      assert property (CORE_RESET_O |-> rst_len_q >= mpss_pkg::RST_MIN_CYC
         && rst_len_q <= RSTMAX_CYCLES) else $error("reset width");
   a_rst_pulse:
      assert property (CORE_RESET_O |=> !CORE_RESET_O) else $error("reset too long");
   a_off_released:
      assert property ($fell(STATUS_O) |-> POWER_KEY_N_I && $past(POWER_KEY_N_I, 8))
         else $error("off with key held");
   c_on: cover property ($rose(STATUS_O));
   c_sleep: cover property ($rose(SLEEP_O));
   c_reset: cover property (CORE_RESET_O);
   c_rwake: cover property (USB_REMOTE_WAKE_O);
endmodule : mpss_chk

bind mpss_top mpss_chk #(.PWRON_CYCLES(PWRON_CYCLES), .RSTMAX_CYCLES(RSTMAX_CYCLES)) CHK (
   .CORE_CLK_I(CORE_CLK_I), .SYS_RST_I(SYS_RST_I), .POWER_KEY_N_I(POWER_KEY_N_I),
   .RESET_N_I(RESET_N_I), .DTR_I(DTR_I), .STATUS_O(STATUS_O), .RI_O(RI_O),
   .USB_REMOTE_WAKE_O(USB_REMOTE_WAKE_O), .SLEEP_O(SLEEP_O), .CORE_RESET_O(CORE_RESET_O));
`default_nettype wire

//--- bench/mpss_host.sv
// host model pressing the power key
`timescale 1ns/1ps
`default_nettype none
module mpss_host #(
   parameter int unsigned SETTLE = 30
) (
   input  wire logic        clk_i,
   input  wire logic        go_i,
   input  wire logic        want_i,
   input  wire logic [15:0] hold_i,
   input  wire logic        status_i,
   output logic             key_n_o,
   output logic             busy_o
);
   logic [15:0] cnt;
   initial begin
      key_n_o = 1'b1;
      busy_o  = 1'b0;
   end
   always @(posedge clk_i) begin
      if (go_i && !busy_o) begin
         busy_o <= 1'b1;
         cnt    <= 16'h0000;
      end else if (busy_o) begin
         cnt <= cnt + 16'h0001;
         // supply taken as stable at go, so settle first
         if (cnt == 16'(SETTLE))
            key_n_o <= 1'b0;
         // release only once status shows what was asked for
         if ((cnt > 16'(SETTLE) + hold_i) && (status_i == want_i)) begin
            key_n_o <= 1'b1;
            busy_o  <= 1'b0;
         end
      end
   end
endmodule : mpss_host
`default_nettype wire

//--- bench/mpss_top_tb_top.sv
// bench for the power and sleep sequencer
`timescale 1ns/1ps
`default_nettype none
module mpss_top_tb_top;
   typedef struct packed {
      logic        wr;
      logic [11:0] a;
      logic [31:0] d;
      logic [31:0] q;
      logic        e;
   } mpss_row_t;
   logic        clk, rst, psel, pen, pwr, rst_n, dtr, rdis_n, hrdy, vbus, susp, usbrx;
   logic        go, want, key_n, hbusy, pready, pslverr, re;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rq;
   logic [15:0] hold;
   wire logic [6:0] outs;
   int          n_mismatch, n_tests;
   mpss_row_t   rows [7];
   logic [2:0]  lvs [3];
   mpss_top #(.PWRON_CYCLES(20), .PWROFF_CYCLES(30), .RSTMAX_CYCLES(2000)) DUT (
      .CORE_CLK_I(clk), .SYS_RST_I(rst), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr),
      .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
      .PSLVERR_O(pslverr), .POWER_KEY_N_I(key_n), .RESET_N_I(rst_n), .DTR_I(dtr),
      .RADIO_DISABLE_N_I(rdis_n), .HOST_READY_SENSE_I(hrdy), .USB_BUS_POWER_INPUT_I(vbus),
      .USB_SUSPEND_I(susp), .USB_RX_ACTIVITY_I(usbrx), .STATUS_O(outs[0]), .RI_O(outs[1]),
      .USB_REMOTE_WAKE_O(outs[2]), .RADIO_ON_O(outs[3]), .CARD_ON_O(outs[4]),
      .SLEEP_O(outs[5]), .CORE_RESET_O(outs[6]));
   mpss_host #(.SETTLE(30)) HOST (.clk_i(clk), .go_i(go), .want_i(want), .hold_i(hold),
      .status_i(outs[0]), .key_n_o(key_n), .busy_o(hbusy));
   task automatic complete_run();
      $display("tests %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : complete_run
   task automatic chk(input logic [31:0] s, input logic [31:0] x);
      n_tests++;
      if (s !== x) begin
         n_mismatch++;
         $display("[ERR] t=%0t seen %h exp %h", $time, s, x);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      psel   <= 1'b1;
      pwr    <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge clk);
      pen <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rq = prdata;
      re = pslverr;
      psel <= 1'b0;
      pen  <= 1'b0;
   endtask : apb
   task automatic wfor(input int b, input logic v, input int n);
      for (int i = 0; i < n && outs[b] !== v; i++)
         @(posedge clk);
      chk(outs[b], v);
   endtask : wfor
   task automatic press(input logic [15:0] h, input logic w);
      @(posedge clk);
      hold <= h;
      want <= w;
      go   <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      do @(posedge clk); while (hbusy !== 1'b0);
   endtask : press
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   // about six times the expected run
   initial begin
      #1_000_000;
      n_mismatch++;
      complete_run();
   end
   initial begin
      {psel, pen, pwr, go, want, hrdy, susp, usbrx, dtr, paddr, pwdata, hold} = '0;
      {rst, rst_n, rdis_n, vbus} = 4'hF;
      n_mismatch = 0;
      n_tests = 0;
      lvs = '{3'h0, 3'h4, 3'h1};
      rows = '{'{1'b0, 12'h000, 32'h0000_0000, 32'h0000_0100, 1'b0},
               '{1'b0, 12'h008, 32'h0000_0000, 32'h0000_0000, 1'b0},
               '{1'b0, 12'h004, 32'h0000_0000, 32'h0000_0000, 1'b0},
               '{1'b0, 12'h00C, 32'h0000_0000, 32'h0000_0000, 1'b1},
               '{1'b1, 12'h00C, 32'h0000_FFFF, 32'h0000_0000, 1'b1},
               '{1'b1, 12'h000, 32'h0000_0417, 32'h0000_0000, 1'b0},
               '{1'b0, 12'h000, 32'h0000_0000, 32'h0000_0417, 1'b0}};
      repeat (8) @(posedge clk);
      chk({pready, outs}, 32'h0000_0080);
      rst <= 1'b0;
      foreach (rows[i]) begin
         apb(rows[i].wr, rows[i].a, rows[i].d);
         if (!rows[i].wr)
            chk(rq, rows[i].q);
         chk(re, rows[i].e);
      end
      $display("register rows done");
      press(16'h000A, 1'b0);
      chk(outs[0], 1'b0);
      press(16'h0014, 1'b1);
      chk(outs[0], 1'b1);
      apb(1'b1, 12'h000, 32'h0000_0100);
      apb(1'b0, 12'h008, 32'h0000_0000);
      chk(rq, 32'h0000_0022);
      foreach (lvs[i]) begin
         apb(1'b1, 12'h000, {21'h0, lvs[i], 8'h00});
         repeat (4) @(posedge clk);
         chk(outs[4:3], {lvs[i] != 3'h0, lvs[i] == 3'h1});
      end
      rdis_n <= 1'b0;
      repeat (5) @(posedge clk);
      chk(outs[3], 1'b1);
      apb(1'b1, 12'h000, 32'h0000_0102);
      repeat (4) @(posedge clk);
      chk(outs[4:3], 2'h2);
      apb(1'b1, 12'h004, 32'h0000_0004);
      apb(1'b0, 12'h008, 32'h0000_0000);
      chk(rq[10:8], 3'h5);
      rdis_n <= 1'b1;
      hrdy   <= 1'b1;
      apb(1'b1, 12'h000, 32'h0000_0100);
      apb(1'b0, 12'h008, 32'h0000_0000);
      chk(rq[10:8], 3'h2);
      apb(1'b1, 12'h004, 32'h0000_0002);
      wfor(1, 1'b1, 20);
      hrdy <= 1'b0;
      dtr  <= 1'b1;
      repeat (10) @(posedge clk);
      chk(outs[5], 1'b0);
      apb(1'b1, 12'h000, 32'h0000_0101);
      wfor(5, 1'b1, 20);
      apb(1'b1, 12'h004, 32'h0000_0002);
      wfor(1, 1'b1, 20);
      dtr <= 1'b0;
      wfor(5, 1'b0, 20);
      $display("power on, levels, uart sleep done");
      apb(1'b1, 12'h000, 32'h0000_0119);
      susp <= 1'b1;
      repeat (10) @(posedge clk);
      chk(outs[5], 1'b0);
      dtr <= 1'b1;
      wfor(5, 1'b1, 20);
      apb(1'b1, 12'h004, 32'h0000_0002);
      wfor(2, 1'b1, 20);
      usbrx <= 1'b1;
      wfor(5, 1'b0, 20);
      {usbrx, susp} <= 2'h0;
      repeat (10) @(posedge clk);
      vbus <= 1'b0;
      wfor(5, 1'b1, 20);
      vbus <= 1'b1;
      wfor(5, 1'b0, 20);
      dtr <= 1'b0;
      apb(1'b1, 12'h000, 32'h0000_0101);
      rst_n <= 1'b0;
      repeat (1100) @(posedge clk);
      rst_n <= 1'b1;
      wfor(6, 1'b1, 20);
      apb(1'b0, 12'h000, 32'h0000_0000);
      chk(rq, 32'h0000_0100);
      wfor(0, 1'b1, 50);
      apb(1'b1, 12'h004, 32'h0000_0001);
      wfor(0, 1'b0, 40);
      press(16'h0014, 1'b1);
      press(16'h0028, 1'b1);
      chk(outs[0], 1'b1);
      wfor(0, 1'b0, 40);
      $display("usb sleep, reset pin, power off done");
      complete_run();
   end
endmodule : mpss_top_tb_top
`default_nettype wire

//--- design/mpss_pkg.sv
// package for the module power and sleep sequencer
package mpss_pkg;

   // clock rate
   localparam int unsigned CLK_HZ = 10_000_000;

   // timing figures as printed
   localparam int unsigned PWRON_MIN_MS = 100;
   localparam int unsigned PWRON_CYC    = (PWRON_MIN_MS * (CLK_HZ / 1000));
   localparam int unsigned CNT_W        = 24;

   // power-off key hold, reset pulse window: not fixed, defaults chosen
   localparam int unsigned PWROFF_MIN_MS = 100;
   localparam int unsigned PWROFF_CYC    = (PWROFF_MIN_MS * (CLK_HZ / 1000));
   localparam int unsigned RST_MIN_US    = 100;
   localparam int unsigned RST_MIN_CYC   = (RST_MIN_US * (CLK_HZ / 1_000_000));
   localparam int unsigned RST_MAX_MS    = 1000;
   localparam int unsigned RST_MAX_CYC   = (RST_MAX_MS * (CLK_HZ / 1000));
   localparam int unsigned PWRDN_DONE_CYC = 16;

   // apb register byte offsets
   localparam logic [11:0] OFS_CTRL   = 12'h0000;
   localparam logic [11:0] OFS_CMD    = 12'h0004;
   localparam logic [11:0] OFS_STATUS = 12'h0008;

   // ctrl fields
   localparam int unsigned CTRL_SLEEP_CLK   = 0;
   localparam int unsigned CTRL_AIRCTL_EN   = 1;
   localparam int unsigned CTRL_HRDY_POL    = 2;
   localparam int unsigned CTRL_REMOTE_WAKE = 3;
   localparam int unsigned CTRL_USB_PATH    = 4;
   localparam int unsigned CTRL_FUN_LSB     = 8;
   localparam int unsigned FUN_W            = 3;
   localparam logic [31:0] CTRL_RESET       = 32'h0000_0100;

   // cmd fields (write one to act)
   localparam int unsigned CMD_POWER_OFF = 0;
   localparam int unsigned CMD_UNSOL     = 1;
   localparam int unsigned CMD_RADIO_REQ = 2;

   // functionality levels
   localparam logic [2:0] FUN_MIN  = 3'h0;
   localparam logic [2:0] FUN_FULL = 3'h1;
   localparam logic [2:0] FUN_AIR  = 3'h4;

   typedef enum logic [2:0] {
      MPSS_OFF,
      MPSS_BOOT,
      MPSS_ON,
      MPSS_SLEEP,
      MPSS_PWRDN
   } mpss_state_t;

   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } mpss_apb_req_t;

endpackage : mpss_pkg

//--- design/mpss_top.sv
// module power, sleep and reset sequencer with apb registers
`timescale 1ns/1ps
`default_nettype none
module mpss_top #(
   parameter int unsigned PWRON_CYCLES  = mpss_pkg::PWRON_CYC,
   parameter int unsigned PWROFF_CYCLES = mpss_pkg::PWROFF_CYC,
   parameter int unsigned RSTMAX_CYCLES = mpss_pkg::RST_MAX_CYC
) (
   // clock and reset
   input  wire logic        CORE_CLK_I,
   input  wire logic        SYS_RST_I,
   // apb slave
   input  wire logic        PSEL_I,
   input  wire logic        PENABLE_I,
   input  wire logic        PWRITE_I,
   input  wire logic [11:0] PADDR_I,
   input  wire logic [31:0] PWDATA_I,
   output logic      [31:0] PRDATA_O,
   output logic             PREADY_O,
   output logic             PSLVERR_O,
   // host pins
   input  wire logic        POWER_KEY_N_I,
   input  wire logic        RESET_N_I,
   input  wire logic        DTR_I,
   input  wire logic        RADIO_DISABLE_N_I,
   input  wire logic        HOST_READY_SENSE_I,
   input  wire logic        USB_BUS_POWER_INPUT_I,
   input  wire logic        USB_SUSPEND_I,
   input  wire logic        USB_RX_ACTIVITY_I,
   // module outputs
   output logic             STATUS_O,
   output logic             RI_O,
   output logic             USB_REMOTE_WAKE_O,
   output logic             RADIO_ON_O,
   output logic             CARD_ON_O,
   output logic             SLEEP_O,
   output logic             CORE_RESET_O
);

   localparam int unsigned SYN_W = 8;

   typedef struct packed {
      logic [SYN_W-1:0]                   s1;
      logic [SYN_W-1:0]                   s2;
      mpss_pkg::mpss_state_t              st;
      logic [mpss_pkg::CNT_W-1:0]         key_cnt;
      logic [mpss_pkg::CNT_W-1:0]         rst_cnt;
      logic [4:0]                         dn_cnt;
      logic                               key_long;
      logic [31:0]                        ctrl;
      logic                               unsol;
      logic                               pwroff_req;
      logic                               rej;
      logic [31:0]                        prdata;
      logic                               pready;
      logic                               pslverr;
      logic                               status;
      logic                               ri;
      logic                               rwake;
      logic                               radio_on;
      logic                               card_on;
      logic                               sleep;
      logic                               core_rst;
   } mpss_regs_t;

   mpss_regs_t            r_q;
   mpss_regs_t            r_d;
   mpss_pkg::mpss_apb_req_t apb;

   // saturating increment, shared by both pin timers
   function automatic logic [mpss_pkg::CNT_W-1:0] mpss_inc(
      input logic [mpss_pkg::CNT_W-1:0] v);
      mpss_inc = (&v) ? v : v + 1'b1;
   endfunction : mpss_inc

   assign apb.psel    = PSEL_I;
   assign apb.penable = PENABLE_I;
   assign apb.pwrite  = PWRITE_I;
   assign apb.paddr   = PADDR_I;
   assign apb.pwdata  = PWDATA_I;

   logic       key_n;
   logic       rst_n;
   logic       dtr;
   logic       radio_dis_n;
   logic       hrdy;
   logic       vbus;
   logic       susp;
   logic       usb_rx;
   logic [2:0] fun;
   logic       airplane;
   logic       host_asleep;
   logic       sleep_ok;
   logic       wake;
   logic       wr;
   logic       rd;

   always_comb begin
      r_d = r_q;
      // two-stage synchronisers; only stage two is read below
      r_d.s1 = {USB_RX_ACTIVITY_I, USB_SUSPEND_I, USB_BUS_POWER_INPUT_I,
                HOST_READY_SENSE_I, RADIO_DISABLE_N_I, DTR_I, RESET_N_I, POWER_KEY_N_I};
      r_d.s2 = r_q.s1;
      {usb_rx, susp, vbus, hrdy, radio_dis_n, dtr, rst_n, key_n} = r_q.s2;

      fun = r_q.ctrl[mpss_pkg::CTRL_FUN_LSB +: mpss_pkg::FUN_W];
      // pin only counts once enabled; pin idles high via pull-up
      airplane = (fun == mpss_pkg::FUN_AIR) || (fun == mpss_pkg::FUN_MIN) ||
                 (r_q.ctrl[mpss_pkg::CTRL_AIRCTL_EN] && !radio_dis_n);
      host_asleep = (hrdy != r_q.ctrl[mpss_pkg::CTRL_HRDY_POL]);

      if (r_q.ctrl[mpss_pkg::CTRL_USB_PATH]) begin
         // bus power removed counts as suspended
         sleep_ok = r_q.ctrl[mpss_pkg::CTRL_SLEEP_CLK] && dtr && (susp || !vbus);
         wake     = !dtr || (usb_rx && vbus) || (vbus && !susp);
      end else begin
         sleep_ok = r_q.ctrl[mpss_pkg::CTRL_SLEEP_CLK] && dtr;
         wake     = !dtr;
      end

      // apb: zero wait states, write at the access cycle, read data latched at the setup cycle
      wr = apb.psel && apb.penable && apb.pwrite;
      rd = apb.psel && apb.penable && !apb.pwrite;
      r_d.pready  = 1'b1;
      r_d.pslverr = 1'b0;
      r_d.prdata  = 32'h0000_0000;
      if (apb.psel && !apb.penable) begin
         if (apb.paddr == mpss_pkg::OFS_CTRL) begin
            r_d.prdata = r_q.ctrl;
         end else if (apb.paddr == mpss_pkg::OFS_CMD) begin
            r_d.prdata = 32'h0000_0000;
         end else if (apb.paddr == mpss_pkg::OFS_STATUS) begin
            r_d.prdata = {16'h0000, 5'h00, r_q.rej, host_asleep, airplane,
                          r_q.unsol, r_q.sleep, r_q.status, 2'b00, r_q.st};
         end else begin
            r_d.pslverr = 1'b1;
         end
      end else if (apb.psel) begin
         r_d.prdata  = r_q.prdata;
         r_d.pslverr = r_q.pslverr;
      end
      if (wr && apb.paddr == mpss_pkg::OFS_CTRL) begin
         r_d.ctrl = apb.pwdata;
      end
      if (wr && apb.paddr == mpss_pkg::OFS_CMD) begin
         if (apb.pwdata[mpss_pkg::CMD_POWER_OFF]) begin
            r_d.pwroff_req = 1'b1;
         end
         if (apb.pwdata[mpss_pkg::CMD_UNSOL]) begin
            r_d.unsol = 1'b1;
         end
         // radio dependent command: sticky reject flag while airplane
         if (apb.pwdata[mpss_pkg::CMD_RADIO_REQ] && airplane) begin
            r_d.rej = 1'b1;
         end
      end
      if (rd && apb.paddr == mpss_pkg::OFS_STATUS) begin
         r_d.rej = 1'b0;
      end

      // radio follows level and, when enabled, the disable pin; card follows level only; positioning is untouched
      r_d.radio_on = (r_q.st == mpss_pkg::MPSS_ON || r_q.st == mpss_pkg::MPSS_SLEEP)
                     && !airplane;
      r_d.card_on  = (r_q.st == mpss_pkg::MPSS_ON || r_q.st == mpss_pkg::MPSS_SLEEP)
                     && (fun != mpss_pkg::FUN_MIN);

      // key timer counts low time
      r_d.key_cnt = key_n ? '0 : mpss_inc(r_q.key_cnt);
      r_d.rst_cnt = rst_n ? '0 : mpss_inc(r_q.rst_cnt);
      r_d.core_rst = 1'b0;
      r_d.ri    = 1'b0;
      r_d.rwake = 1'b0;

      case (r_q.st)
         mpss_pkg::MPSS_OFF: begin
            r_d.status = 1'b0;
            r_d.sleep  = 1'b0;
            r_d.pwroff_req = 1'b0;
            // short presses never reach the count
            if (r_q.key_cnt >= mpss_pkg::CNT_W'(PWRON_CYCLES)) begin
               r_d.st = mpss_pkg::MPSS_BOOT;
            end
         end
         mpss_pkg::MPSS_BOOT: begin
            r_d.status   = 1'b1;
            r_d.key_long = 1'b0;
            // wait for release so the turn-on press is not read as turn-off
            if (key_n) begin
               r_d.st = mpss_pkg::MPSS_ON;
            end
         end
         mpss_pkg::MPSS_ON: begin
            r_d.sleep = 1'b0;
            if (r_q.key_cnt >= mpss_pkg::CNT_W'(PWROFF_CYCLES)) begin
               r_d.key_long = 1'b1;
            end
            if ((r_q.key_long && key_n) || r_q.pwroff_req) begin
               r_d.st     = mpss_pkg::MPSS_PWRDN;
               r_d.dn_cnt = '0;
            end else if (r_q.unsol && host_asleep) begin
               r_d.ri    = 1'b1;
               r_d.unsol = 1'b0;
            end else if (sleep_ok && !r_q.unsol && !wake) begin
               // usb data while suspended must not bounce back into sleep
               r_d.st = mpss_pkg::MPSS_SLEEP;
            end
         end
         mpss_pkg::MPSS_SLEEP: begin
            r_d.sleep = 1'b1;
            if (wake || !sleep_ok) begin
               r_d.st = mpss_pkg::MPSS_ON;
            end else if (r_q.unsol) begin
               r_d.unsol = 1'b0;
               if (r_q.ctrl[mpss_pkg::CTRL_USB_PATH] && r_q.ctrl[mpss_pkg::CTRL_REMOTE_WAKE]) begin
                  r_d.rwake = 1'b1;
               end else begin
                  r_d.ri = 1'b1;
               end
            end
            if (!key_n || r_q.pwroff_req) begin
               r_d.st = mpss_pkg::MPSS_ON;
            end
         end
         mpss_pkg::MPSS_PWRDN: begin
            r_d.sleep  = 1'b0;
            r_d.dn_cnt = r_q.dn_cnt + 5'd1;
            r_d.pwroff_req = 1'b0;
            if (r_q.dn_cnt == 5'(mpss_pkg::PWRDN_DONE_CYC)) begin
               r_d.status   = 1'b0;
               r_d.key_long = 1'b0;
               r_d.st       = mpss_pkg::MPSS_OFF;
            end
         end
         default: begin
            r_d.st = mpss_pkg::MPSS_OFF;
         end
      endcase

      // reset pulse acts on release, only inside the width window
      if (rst_n && r_q.rst_cnt >= mpss_pkg::CNT_W'(mpss_pkg::RST_MIN_CYC) &&
          r_q.rst_cnt <= mpss_pkg::CNT_W'(RSTMAX_CYCLES) &&
          r_q.st != mpss_pkg::MPSS_OFF) begin
         r_d.core_rst = 1'b1;
         r_d.st       = mpss_pkg::MPSS_BOOT;
         r_d.unsol    = 1'b0;
         r_d.ctrl     = mpss_pkg::CTRL_RESET;
      end
   end

   always_ff @(posedge CORE_CLK_I) begin
      if (SYS_RST_I) begin
         r_q <= '0;
         r_q.s1 <= '1;
         r_q.s2 <= '1;
         r_q.st <= mpss_pkg::MPSS_OFF;
         r_q.ctrl <= mpss_pkg::CTRL_RESET;
         r_q.pready <= 1'b1;
      end else begin
         r_q <= r_d;
      end
   end

   assign PRDATA_O          = r_q.prdata;
   assign PREADY_O          = r_q.pready;
   assign PSLVERR_O         = r_q.pslverr;
   assign STATUS_O          = r_q.status;
   assign RI_O              = r_q.ri;
   assign USB_REMOTE_WAKE_O = r_q.rwake;
   assign RADIO_ON_O        = r_q.radio_on;
   assign CARD_ON_O         = r_q.card_on;
   assign SLEEP_O           = r_q.sleep;
   assign CORE_RESET_O      = r_q.core_rst;

endmodule : mpss_top
`default_nettype wire
